// >>> rtl/iprc_pkg.sv
/*
  Constants, types and shared functions of the interrupt priority
  controller. Assumes 32 request lines, vector 0 being the reset vector.
*/
package iprc_pkg;

  localparam int NVEC = 32;

  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h01;
  localparam logic [7:0] OFS_LAST = 8'h02;
  localparam logic [7:0] OFS_PROMO = 8'h03;

  // Field positions
  localparam int CTRL_RR_BIT = 0;
  localparam int CTRL_COMPACT_BIT = 5;
  localparam int CTRL_PLACE_BIT = 6;
  localparam int STAT_LO_BIT = 0;
  localparam int STAT_HI_BIT = 1;
  localparam int STAT_NMI_BIT = 7;
  localparam logic [7:0] CTRL_WMASK = 8'h61;
  localparam logic [7:0] CTRL_PROT_MASK = 8'h60;

  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_LAST = 8'h00;
  localparam logic [7:0] RST_PROMO = 8'h00;

  // Lines wired as unmaskable; fixed when the chip is built
  localparam logic [NVEC-1:0] NMI_LINES = 32'h0000_0002;

  // Compact table slots
  localparam logic [7:0] COMPACT_SLOT_NMI = 8'h01;
  localparam logic [7:0] COMPACT_SLOT_HI = 8'h02;
  localparam logic [7:0] COMPACT_SLOT_LO = 8'h03;

  // Boot section start, word address
  localparam logic [15:0] BOOT_BASE = 16'h0000;

  // Protected write window, in retired instructions
  localparam logic [2:0] PROT_WINDOW_INSTR = 3'h4;

  typedef enum logic [1:0] {LVL_NORMAL, LVL_HIGH, LVL_NMI} iprc_level_t;

  typedef struct packed {
    logic valid;
    iprc_level_t level;
    logic [7:0] vec;
    logic [15:0] addr;
  } iprc_vreq_t;

  typedef struct packed {
    logic nmi;
    logic hi;
    logic lo;
  } iprc_flags_t;

  function automatic logic [7:0] iprc_lowest(input logic [NVEC-1:0] p);
    logic [7:0] idx;
    idx = 8'h00;
    for (int i = NVEC - 1; i >= 0; i--)
    begin
      if (p[i])
        idx = 8'(i);
    end
    return idx;
  endfunction : iprc_lowest

endpackage : iprc_pkg

// >>> rtl/iprc_rr_pick.sv
/*
  Rotating pick among pending normal-level vectors: the lowest pending
  vector above the start point, else the lowest pending overall.
  Purely combinational; caller registers the result.
*/
`timescale 1ns/1ps
module iprc_rr_pick
  import iprc_pkg::*;
(
  // Candidates
  input wire logic [NVEC-1:0] pend,
  input wire logic [7:0] start,
  // Result
  output logic found,
  output logic [7:0] idx
);

  logic [NVEC-1:0] above;

  always_comb
  begin
    above = '0;
    for (int i = 0; i < NVEC; i++)
    begin
      if (8'(i) > start)
        above[i] = pend[i];
    end
    found = |pend;
    // Wrap to the bottom when nothing lies above the start point
    if (|above)
      idx = iprc_lowest(above);
    else
      idx = iprc_lowest(pend);
  end

endmodule : iprc_rr_pick

// >>> rtl/iprc_arbiter.sv
/*
  Interrupt priority controller: arbitrates unmaskable, high and normal
  requests, presents a vector to the core and tracks executing levels.
  Assumes request lines and core strobes come from logic on clk_sys.
*/
`timescale 1ns/1ps
module iprc_arbiter
  import iprc_pkg::*;
(
  // Clock, enable, reset
  input wire logic clk_sys,
  input wire logic ce,
  input wire logic srst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  // Peripheral requests
  input wire logic [NVEC-1:0] irq_req,
  // Core side
  input wire logic gie,
  input wire logic prot_unlock,
  input wire logic instr_done,
  input wire logic [15:0] boot_boundary_fuse,
  input wire logic cpu_ack,
  input wire logic irq_ret,
  output iprc_vreq_t vreq,
  output iprc_flags_t executing
);

  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] last_r, last_nxt;
  logic [7:0] promo_r, promo_nxt;
  iprc_flags_t flags_r, flags_nxt;
  logic [2:0] prot_cnt_r, prot_cnt_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  iprc_vreq_t vreq_r, vreq_nxt;

  logic [NVEC-1:0] nmi_pend, lo_pend, promo_hot;
  logic [NVEC-1:0] lo_below;
  logic hi_pend, lo_found, rr_on, compact_on;
  logic [7:0] lo_idx, nmi_low, rr_start, compact_slot;
  logic [15:0] vec_base;
  iprc_vreq_t win;

  assign rr_on = ctrl_r[CTRL_RR_BIT];
  assign compact_on = ctrl_r[CTRL_COMPACT_BIT];
  assign rr_start = rr_on ? last_r : 8'h00;

  iprc_rr_pick u_pick (
    .pend(lo_pend),
    .start(rr_start),
    .found(lo_found),
    .idx(lo_idx)
  );

  // Request sorting; kept apart from the pick to avoid a loop
  always_comb
  begin
    nmi_pend = irq_req & NMI_LINES;
    promo_hot = '0;
    if (promo_r != 8'h00 && promo_r < 8'(NVEC))
      promo_hot[promo_r[4:0]] = 1'b1;
    hi_pend = |(irq_req & promo_hot & ~NMI_LINES);
    // Vector 0 is reset, never a request
    lo_pend = irq_req & ~NMI_LINES & ~promo_hot;
    lo_pend[0] = 1'b0;
  end

  // Arbitration
  always_comb
  begin
    nmi_low = iprc_lowest(nmi_pend);
    win = '0;
    compact_slot = COMPACT_SLOT_LO;
    if (|nmi_pend && !flags_r.nmi)
    begin
      win.valid = 1'b1;
      win.level = LVL_NMI;
      win.vec = nmi_low;
      compact_slot = COMPACT_SLOT_NMI;
    end
    else if (!flags_r.nmi && gie && !flags_r.hi && hi_pend)
    begin
      win.valid = 1'b1;
      win.level = LVL_HIGH;
      win.vec = promo_r;
      compact_slot = COMPACT_SLOT_HI;
    end
    else if (!flags_r.nmi && gie && !flags_r.hi && !flags_r.lo
             && lo_found)
    begin
      win.valid = 1'b1;
      win.level = LVL_NORMAL;
      win.vec = lo_idx;
    end
    // Application start comes from the boot boundary fuse
    if (ctrl_r[CTRL_PLACE_BIT])
      vec_base = BOOT_BASE;
    else
      vec_base = boot_boundary_fuse;
    if (compact_on)
      win.addr = vec_base + {7'h00, compact_slot, 1'b0};
    else
      win.addr = vec_base + {7'h00, win.vec, 1'b0};
  end

  // Pending normal vectors below the pick; read by checks only
  always_comb
  begin
    lo_below = '0;
    for (int i = 0; i < NVEC; i++)
    begin
      if (8'(i) < win.vec)
        lo_below[i] = lo_pend[i];
    end
  end

  // Registers, status and presentation
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    last_nxt = last_r;
    promo_nxt = promo_r;
    flags_nxt = flags_r;
    prot_cnt_nxt = prot_cnt_r;
    rdata_nxt = 8'h00;
    if (prot_unlock)
      prot_cnt_nxt = PROT_WINDOW_INSTR;
    else if (instr_done && prot_cnt_r != 3'h0)
      prot_cnt_nxt = prot_cnt_r - 3'h1;
    if (reg_we)
    begin
      case (reg_addr)
        OFS_CTRL:
        begin
          // Locked bits keep their value; the write itself is not refused
          if (prot_cnt_r != 3'h0)
            ctrl_nxt = reg_wdata & CTRL_WMASK;
          else
            ctrl_nxt = (ctrl_r & CTRL_PROT_MASK)
                     | (reg_wdata & CTRL_WMASK & ~CTRL_PROT_MASK);
        end
        OFS_LAST: last_nxt = reg_wdata;
        OFS_PROMO: promo_nxt = reg_wdata;
        default: ;
      endcase
    end
    // Return clears the innermost level only
    if (irq_ret)
    begin
      if (flags_r.nmi)
        flags_nxt.nmi = 1'b0;
      else if (flags_r.hi)
        flags_nxt.hi = 1'b0;
      else
        flags_nxt.lo = 1'b0;
    end
    // Acknowledge after return so a same-cycle set wins
    if (cpu_ack && vreq_r.valid)
    begin
      case (vreq_r.level)
        LVL_NMI: flags_nxt.nmi = 1'b1;
        LVL_HIGH: flags_nxt.hi = 1'b1;
        default:
        begin
          flags_nxt.lo = 1'b1;
          if (rr_on)
            last_nxt = vreq_r.vec;
        end
      endcase
    end
    if (reg_re)
    begin
      case (reg_addr)
        OFS_CTRL: rdata_nxt = ctrl_r;
        OFS_STAT:
        begin
          rdata_nxt[STAT_NMI_BIT] = flags_r.nmi;
          rdata_nxt[STAT_HI_BIT] = flags_r.hi;
          rdata_nxt[STAT_LO_BIT] = flags_r.lo;
        end
        OFS_LAST: rdata_nxt = last_r;
        OFS_PROMO: rdata_nxt = promo_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
    // Hide the request for the cycle the flags take to update
    vreq_nxt = win;
    if (cpu_ack)
      vreq_nxt.valid = 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ctrl_r <= RST_CTRL;
      last_r <= RST_LAST;
      promo_r <= RST_PROMO;
      flags_r <= '0;
      prot_cnt_r <= 3'h0;
      rdata_r <= 8'h00;
      vreq_r <= '0;
    end
    else if (ce)
    begin
      ctrl_r <= ctrl_nxt;
      last_r <= last_nxt;
      promo_r <= promo_nxt;
      flags_r <= flags_nxt;
      prot_cnt_r <= prot_cnt_nxt;
      rdata_r <= rdata_nxt;
      vreq_r <= vreq_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign vreq = vreq_r;
  assign executing = flags_r;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  AST_NMI_NO_GIE: assert property (
    ce && |nmi_pend && !flags_r.nmi && !cpu_ack
    |=> vreq_r.valid && vreq_r.level == LVL_NMI)
    else $error("unmaskable request not presented");

  AST_NMI_BLOCKS: assert property (
    ce && flags_r.nmi |=> !vreq_r.valid)
    else $error("request presented inside unmaskable handler");

  AST_NMI_LOWEST: assert property (
    ce && win.valid && win.level == LVL_NMI && !cpu_ack
    |=> vreq_r.vec == $past(nmi_low))
    else $error("unmaskable not lowest vector");

  AST_FIXED_LOWEST: assert property (
    ce && win.valid && win.level == LVL_NORMAL && !rr_on
    |-> lo_below == '0 && lo_pend[win.vec[4:0]])
    else $error("fixed scheme did not pick lowest");

  AST_RR_SKIP_LAST: assert property (
    ce && win.valid && win.level == LVL_NORMAL && rr_on && !cpu_ack
    && $countones(lo_pend) > 1
    |=> vreq_r.vec != $past(last_r))
    else $error("rotation picked last served vector");

  AST_RR_CAPTURE: assert property (
    ce && cpu_ack && vreq_r.valid && vreq_r.level == LVL_NORMAL && rr_on
    |=> last_r == $past(vreq_r.vec))
    else $error("last served not captured");

  AST_COMPACT_ADDR: assert property (
    ce && win.valid && compact_on && !cpu_ack
    |=> vreq_r.addr == $past(vec_base) + {7'h00, $past(compact_slot), 1'b0})
    else $error("compact vector address wrong");

  AST_PROT_LOCK: assert property (
    ce && reg_we && reg_addr == OFS_CTRL && prot_cnt_r == 3'h0
    |=> ctrl_r[CTRL_PLACE_BIT] == $past(ctrl_r[CTRL_PLACE_BIT])
        && ctrl_r[CTRL_COMPACT_BIT] == $past(ctrl_r[CTRL_COMPACT_BIT]))
    else $error("protected bits changed while locked");

  AST_RETURN_NMI: assert property (
    ce && irq_ret && flags_r.nmi && !cpu_ack
    |=> !flags_r.nmi && flags_r.hi == $past(flags_r.hi)
        && flags_r.lo == $past(flags_r.lo))
    else $error("return did not restore prior level");

  AST_HI_NOT_PREEMPTED: assert property (
    ce && flags_r.hi |=> !(vreq_r.valid && vreq_r.level == LVL_NORMAL))
    else $error("normal request preempted high handler");

  AST_GIE_MASK: assert property (
    ce && !gie |=> !(vreq_r.valid && vreq_r.level != LVL_NMI))
    else $error("maskable request with interrupts disabled");

  AST_UNUSED_ZERO: assert property (
    ce && reg_re && reg_addr == OFS_CTRL
    |=> reg_rdata[4:1] == 4'h0 && !reg_rdata[7])
    else $error("unused control bits not zero");

  AST_PROT_OPEN: assert property (
    ce && reg_we && reg_addr == OFS_CTRL && prot_cnt_r != 3'h0
    |=> ctrl_r == ($past(reg_wdata) & CTRL_WMASK))
    else $error("protected write refused inside window");

  AST_HI_PRESENT: assert property (
    ce && gie && hi_pend && !(|nmi_pend) && !flags_r.nmi && !flags_r.hi
    && !cpu_ack |=> vreq_r.valid && vreq_r.level == LVL_HIGH)
    else $error("high request not presented");

  AST_PROMO_OFF: assert property (
    ce && promo_r == 8'h00
    |=> !(vreq_r.valid && vreq_r.level == LVL_HIGH))
    else $error("high level served with no promoted vector");

  AST_RETURN_HI: assert property (
    ce && irq_ret && !flags_r.nmi && flags_r.hi && !cpu_ack
    |=> !flags_r.hi && flags_r.lo == $past(flags_r.lo))
    else $error("return from high did not restore prior level");

  AST_NMI_FLAG: assert property (
    ce && cpu_ack && vreq_r.valid && vreq_r.level == LVL_NMI
    |=> flags_r.nmi)
    else $error("unmaskable flag not set on acknowledge");

  AST_LAST_FIXED: assert property (
    ce && !rr_on && !(reg_we && reg_addr == OFS_LAST)
    |=> last_r == $past(last_r))
    else $error("last served changed in fixed scheme");

  COV_NMI_ACK: cover property (
    cpu_ack && vreq_r.valid && vreq_r.level == LVL_NMI);
  COV_RR_ACK: cover property (
    cpu_ack && vreq_r.valid && vreq_r.level == LVL_NORMAL && rr_on);
  COV_NEST: cover property (
    flags_r.lo && cpu_ack && vreq_r.valid && vreq_r.level == LVL_HIGH);
  COV_COMPACT: cover property (cpu_ack && vreq_r.valid && compact_on);

endmodule : iprc_arbiter

// >>> tb/iprc_core_model.sv
/*
  Core model: takes each presented vector after dly idle cycles.
  Assumes vreq is registered on clk_sys.
*/
`timescale 1ns/1ps
module iprc_core_model
  import iprc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Vector side
  input wire iprc_vreq_t vreq,
  input wire logic [3:0] dly,
  output logic cpu_ack,
  // Observation
  output iprc_vreq_t seen,
  output logic [7:0] n_ack
);
  logic [3:0] cnt;

  // Ack held off until the taking edge has dropped valid
  always_ff @(posedge clk_sys)
  begin
    cpu_ack <= 1'b0;
    if (srst)
    begin
      cnt <= 4'h0;
      n_ack <= 8'h00;
    end
    else
    begin
      if (vreq.valid && !cpu_ack)
      begin
        cnt <= cnt + 4'h1;
        if (cnt >= dly)
        begin
          cpu_ack <= 1'b1;
          cnt <= 4'h0;
        end
      end
      if (cpu_ack)
      begin
        seen <= vreq;
        n_ack <= n_ack + 8'h01;
      end
    end
  end
endmodule : iprc_core_model

// >>> tb/testbench.sv
/*
  Self-checking bench of the interrupt priority controller.
  Assumes the core model acks every vector it is shown.
*/
`timescale 1ns/1ps
module testbench
  import iprc_pkg::*;
;
  localparam logic [15:0] FUSE = 16'h0100;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [7:0] reg_rdata;
  logic [NVEC-1:0] irq_req = '0;
  logic gie = 1'b0;
  logic ce = 1'b1;
  logic prot_unlock = 1'b0;
  logic instr_done = 1'b0;
  logic irq_ret = 1'b0;
  iprc_flags_t executing;
  logic cpu_ack;
  logic [3:0] dly = 4'h0;
  logic [7:0] n_ack;
  iprc_vreq_t vreq;
  iprc_vreq_t seen;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;

  always #2.5 clk_sys = ~clk_sys;

  iprc_arbiter iprc_arbiter_i (.clk_sys(clk_sys), .ce(ce),
    .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .irq_req(irq_req), .gie(gie), .prot_unlock(prot_unlock),
    .instr_done(instr_done), .boot_boundary_fuse(FUSE),
    .cpu_ack(cpu_ack), .irq_ret(irq_ret), .vreq(vreq),
    .executing(executing));

  iprc_core_model iprc_core_model_i (.clk_sys(clk_sys), .srst(srst),
    .vreq(vreq), .dly(dly), .cpu_ack(cpu_ack), .seen(seen),
    .n_ack(n_ack));

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [26:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk_sys);
    reg_we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    #1;
    chk("reg_rdata", {19'h0, e}, {19'h0, reg_rdata});
  endtask : rd

  // 0 return, 1 unlock key seen, 2 retired instruction
  task automatic pulse(input int s);
    @(posedge clk_sys);
    irq_ret <= (s == 0);
    prot_unlock <= (s == 1);
    instr_done <= (s == 2);
    @(posedge clk_sys);
    {irq_ret, prot_unlock, instr_done} <= 3'b000;
  endtask : pulse

  task automatic sq(input logic [NVEC-1:0] q, input logic g);
    @(posedge clk_sys);
    irq_req <= q;
    gie <= g;
  endtask : sq

  task automatic take(input iprc_level_t lv, input logic [15:0] a);
    logic [7:0] k;
    k = n_ack;
    repeat (40)
    begin
      @(posedge clk_sys);
      #1;
      if (n_ack !== k)
        break;
    end
    chk("ack_count", {19'h0, k + 8'h01}, {19'h0, n_ack});
    chk("level_addr", {9'h0, lv, a}, {9'h0, seen.level, seen.addr});
  endtask : take

  task automatic idle();
    logic [7:0] k;
    k = n_ack;
    repeat (12) @(posedge clk_sys);
    #1;
    chk("no_ack", {19'h0, k}, {19'h0, n_ack});
  endtask : idle

  // Whole run needs well under 2000 cycles
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_fail++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    rd(OFS_CTRL, 8'h00);
    rd(OFS_STAT, 8'h00);
    rd(OFS_LAST, 8'h00);
    rd(OFS_PROMO, 8'h00);
    rd(8'h04, 8'h00);
    wr(OFS_CTRL, 8'hff);
    rd(OFS_CTRL, 8'h01);
    wr(OFS_STAT, 8'hff);
    rd(OFS_STAT, 8'h00);
    wr(OFS_CTRL, 8'h00);
    // Frozen block must ignore a write
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(OFS_LAST, 8'h5a);
    ce <= 1'b1;
    rd(OFS_LAST, 8'h00);
    $display("test registers done");
    sq(32'h28, 1'b0);
    idle();
    sq(32'h28, 1'b1);
    take(LVL_NORMAL, FUSE + 16'h6);
    rd(OFS_STAT, 8'h01);
    idle();
    sq(32'h20, 1'b1);
    pulse(0);
    take(LVL_NORMAL, FUSE + 16'ha);
    sq(32'h0, 1'b1);
    pulse(0);
    rd(OFS_STAT, 8'h00);
    $display("test fixed priority done");
    dly <= 4'h3;
    sq(32'h0a, 1'b0);
    take(LVL_NMI, FUSE + 16'h2);
    rd(OFS_STAT, 8'h80);
    sq(32'h08, 1'b1);
    idle();
    pulse(0);
    take(LVL_NORMAL, FUSE + 16'h6);
    wr(OFS_PROMO, 8'h04);
    rd(OFS_PROMO, 8'h04);
    sq(32'h10, 1'b1);
    take(LVL_HIGH, FUSE + 16'h8);
    rd(OFS_STAT, 8'h03);
    sq(32'h22, 1'b1);
    take(LVL_NMI, FUSE + 16'h2);
    rd(OFS_STAT, 8'h83);
    chk("executing", 27'h7, {24'h0, executing});
    sq(32'h20, 1'b1);
    pulse(0);
    rd(OFS_STAT, 8'h03);
    idle();
    pulse(0);
    rd(OFS_STAT, 8'h01);
    idle();
    sq(32'h0, 1'b1);
    pulse(0);
    rd(OFS_STAT, 8'h00);
    $display("test nesting done");
    wr(OFS_PROMO, 8'h00);
    wr(OFS_CTRL, 8'h01);
    wr(OFS_LAST, 8'h03);
    rd(OFS_LAST, 8'h03);
    sq(32'h3c, 1'b1);
    take(LVL_NORMAL, FUSE + 16'h8);
    rd(OFS_LAST, 8'h04);
    sq(32'h2c, 1'b1);
    pulse(0);
    take(LVL_NORMAL, FUSE + 16'ha);
    sq(32'h0c, 1'b1);
    pulse(0);
    take(LVL_NORMAL, FUSE + 16'h4);
    sq(32'h0, 1'b1);
    pulse(0);
    $display("test rotation done");
    pulse(1);
    repeat (3) pulse(2);
    wr(OFS_CTRL, 8'h60);
    rd(OFS_CTRL, 8'h60);
    pulse(1);
    repeat (4) pulse(2);
    wr(OFS_CTRL, 8'h01);
    rd(OFS_CTRL, 8'h61);
    sq(32'h22, 1'b1);
    take(LVL_NMI, BOOT_BASE + 16'h2);
    sq(32'h20, 1'b1);
    pulse(0);
    take(LVL_NORMAL, BOOT_BASE + 16'h6);
    sq(32'h0, 1'b1);
    pulse(0);
    rd(OFS_STAT, 8'h00);
    chk("executing", 27'h0, {24'h0, executing});
    $display("test compact table done");
    print_verdict();
  end
endmodule : testbench
